// File: logic/gpx_pkg.sv
// package for the two-port gpio block with serial pin sharing
package gpx_pkg;
  // port width and reset values
  localparam int PORT_W = 8;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF; // all inputs after reset
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] FSEL_RST = 8'h00; // port logic owns every pin
  localparam logic [7:0] IEN_RST = 8'h00;
  // shared pin positions on the second port
  localparam int PIN_CLK0 = 0;
  localparam int PIN_DAT1 = 1;
  localparam int PIN_SCK2 = 2;

  // protocol selection for the shared serial channel
  typedef enum logic [1:0] {
    GPX_PROTO_SPI = 2'h0,
    GPX_PROTO_TWI = 2'h1,
    GPX_PROTO_UART = 2'h3
  } gpx_proto_t;

  // per-port software configuration
  typedef struct packed {
    logic [7:0] data;   // output level
    logic [7:0] dir;    // 1 = input
    logic [7:0] mode;   // 0 = open-drain style, 1 = open-source style, when output
    logic [7:0] ien;    // pin interrupt enable
    logic [7:0] ipol;   // 1 = interrupt on high level, 0 = low level
  } gpx_cfg_t;

  // two-signal pin bundle
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } gpx_pad_t;

  // serial unit side of the shared pins
  typedef struct packed {
    gpx_proto_t proto;
    logic spi_master;
    logic miso_o;       // slave-mode transmit data
    logic mosi_o;       // master-mode transmit data
    logic sck_o;        // master-mode clock
    logic twi_scl_low;  // 1 pulls clock low
    logic twi_sda_low;  // 1 pulls data low
    logic txd_o;
    logic rts_n;
  } gpx_ser_out_t;

  typedef struct packed {
    logic miso_i;
    logic mosi_i;
    logic sck_i;
    logic twi_scl_i;
    logic twi_sda_i;
    logic rxd_i;
  } gpx_ser_in_t;
endpackage

// File: logic/gpx_pin.sv
// one port pin: pad driver style, input synchroniser and interrupt flag
`timescale 1ns/1ns
module gpx_pin (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pad_i,
  input wire logic data,
  input wire logic dir_in,
  input wire logic src_style,
  input wire logic ien,
  input wire logic ipol,
  input wire logic int_clr,
  output logic pad_o,
  output logic pad_oe,
  output logic sync_o,
  output logic int_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic s1_reg, s1_next;   // first stage, read only by second
  logic s2_reg, s2_next;   // safe sampled level
  logic flag_reg, flag_next; // sticky interrupt flag
  logic hit;

  // drive style: open-drain drives only low, open-source only high
  always_comb begin
    pad_o = data;
    pad_oe = 1'b0;
    if (!dir_in) begin
      pad_oe = src_style ? data : !data;
    end
  end

  // next values for the synchroniser and flag
  always_comb begin
    s1_next = pad_i;
    s2_next = s1_reg;
    hit = ien && (s2_reg == ipol);
    // a new hit in the clearing cycle wins
    flag_next = hit ? 1'b1 : (int_clr ? 1'b0 : flag_reg);
  end

  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      flag_reg <= flag_next;
    end
  end

  assign sync_o = s2_reg;
  assign int_o = flag_reg;
endmodule

// File: logic/gpx_port.sv
// two 8-bit gpio ports, second port shared with a serial channel
// What this block does
// - each pin independently input or output
// - each pin can be an interrupt input
// - outputs select open-drain or open-source drive
// - second port pins 0 to 2 shared with serial channel
// - spi pin 0 input as master, output slave
// - spi pin 1 output as master, input slave
// - twowire clock pin 0, data pin 1
// - uart transmit pin 0, receive pin 1
// - uart pin 2 outputs active-low request-to-send
// - spi clock pin 2, driven only as master
`timescale 1ns/1ns
module gpx_port #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire gpx_pkg::gpx_cfg_t cfg_a,
  input wire gpx_pkg::gpx_cfg_t cfg_b,
  input wire logic [7:0] fsel_b,
  input wire logic [7:0] int_clr_a,
  input wire logic [7:0] int_clr_b,
  input wire logic [7:0] pad_a_i,
  input wire logic [7:0] pad_b_i,
  input wire gpx_pkg::gpx_ser_out_t ser_o,
  output gpx_pkg::gpx_ser_in_t ser_i,
  output gpx_pkg::gpx_pad_t pad_a,
  output gpx_pkg::gpx_pad_t pad_b,
  output logic [7:0] in_a,
  output logic [7:0] in_b,
  output logic [7:0] int_a,
  output logic [7:0] int_b,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // per-pin cells
  logic [7:0] gp_b_o, gp_b_oe;
  logic [7:0] pad_a_o_w, pad_a_oe_w;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pin
      // first port, always port owned
      gpx_pin u_a (
        .clk(clk), .rstn(rstn), .pad_i(pad_a_i[g]),
        .data(cfg_a.data[g]), .dir_in(cfg_a.dir[g]), .src_style(cfg_a.mode[g]),
        .ien(cfg_a.ien[g]), .ipol(cfg_a.ipol[g]), .int_clr(int_clr_a[g]),
        .pad_o(pad_a_o_w[g]), .pad_oe(pad_a_oe_w[g]), .sync_o(in_a[g]), .int_o(int_a[g])
      );
      // second port, pin may be handed to the serial unit
      gpx_pin u_b (
        .clk(clk), .rstn(rstn), .pad_i(pad_b_i[g]),
        .data(cfg_b.data[g]), .dir_in(cfg_b.dir[g]), .src_style(cfg_b.mode[g]),
        .ien(cfg_b.ien[g]), .ipol(cfg_b.ipol[g]), .int_clr(int_clr_b[g]),
        .pad_o(gp_b_o[g]), .pad_oe(gp_b_oe[g]), .sync_o(in_b[g]), .int_o(int_b[g])
      );
    end
  endgenerate

  assign pad_a.o = pad_a_o_w;
  assign pad_a.oe = pad_a_oe_w;
  // one combined interrupt line
  assign irq = |{int_a, int_b};

  ////////////////////////////////////////////////////////////////////////////
  // serial function pin drive for the three shared pins
  logic [2:0] sr_o, sr_oe;
  always_comb begin
    sr_o = 3'h0;
    sr_oe = 3'h0;
    case (ser_o.proto)
      gpx_pkg::GPX_PROTO_SPI: begin
        sr_o[gpx_pkg::PIN_CLK0] = ser_o.miso_o;
        sr_oe[gpx_pkg::PIN_CLK0] = !ser_o.spi_master;
        sr_o[gpx_pkg::PIN_DAT1] = ser_o.mosi_o;
        sr_oe[gpx_pkg::PIN_DAT1] = ser_o.spi_master;
        sr_o[gpx_pkg::PIN_SCK2] = ser_o.sck_o;
        sr_oe[gpx_pkg::PIN_SCK2] = ser_o.spi_master;
      end
      gpx_pkg::GPX_PROTO_TWI: begin
        // open-drain: drive low only, the bus pull-up gives high
        sr_oe[gpx_pkg::PIN_CLK0] = ser_o.twi_scl_low;
        sr_oe[gpx_pkg::PIN_DAT1] = ser_o.twi_sda_low;
      end
      gpx_pkg::GPX_PROTO_UART: begin
        sr_o[gpx_pkg::PIN_CLK0] = ser_o.txd_o;
        sr_oe[gpx_pkg::PIN_CLK0] = 1'b1;
        sr_o[gpx_pkg::PIN_SCK2] = ser_o.rts_n;
        sr_oe[gpx_pkg::PIN_SCK2] = 1'b1;
      end
      default: begin
        sr_o = 3'h0;
        sr_oe = 3'h0;
      end
    endcase
  end

  // pin ownership mux: serial owns a pin only when selected
  always_comb begin
    pad_b.o = gp_b_o;
    pad_b.oe = gp_b_oe;
    for (int i = 0; i < 3; i++) begin
      if (fsel_b[i]) begin
        pad_b.o[i] = sr_o[i];
        pad_b.oe[i] = sr_oe[i];
      end
    end
  end

  // serial receive side reads synchronised pin levels; idle-high when not owned
  always_comb begin
    ser_i.miso_i = fsel_b[gpx_pkg::PIN_CLK0] ? in_b[gpx_pkg::PIN_CLK0] : 1'b1;
    ser_i.twi_scl_i = fsel_b[gpx_pkg::PIN_CLK0] ? in_b[gpx_pkg::PIN_CLK0] : 1'b1;
    ser_i.mosi_i = fsel_b[gpx_pkg::PIN_DAT1] ? in_b[gpx_pkg::PIN_DAT1] : 1'b1;
    ser_i.twi_sda_i = fsel_b[gpx_pkg::PIN_DAT1] ? in_b[gpx_pkg::PIN_DAT1] : 1'b1;
    ser_i.rxd_i = fsel_b[gpx_pkg::PIN_DAT1] ? in_b[gpx_pkg::PIN_DAT1] : 1'b1;
    ser_i.sck_i = fsel_b[gpx_pkg::PIN_SCK2] ? in_b[gpx_pkg::PIN_SCK2] : 1'b1;
  end
endmodule

// File: test/gpx_ext.sv
// far-side circuitry model for one 8-pin port
`timescale 1ns/1ns
module gpx_ext (
  input gpx_pkg::gpx_pad_t pad,
  input logic [7:0] ext,
  output logic [7:0] level
);
  // outside source is resistive, so a driving pad wins over it
  assign level = (pad.oe & pad.o) | (~pad.oe & ext);
endmodule

// File: test/gpx_port_props.sv
// assertions on the ports of the gpio block
`timescale 1ns/1ns
module gpx_port_props (
  input logic clk, rstn, irq,
  input gpx_pkg::gpx_cfg_t cfg_a, cfg_b,
  input gpx_pkg::gpx_ser_out_t ser_o,
  input gpx_pkg::gpx_pad_t pad_a, pad_b,
  input logic [7:0] fsel_b, int_clr_a, pad_a_i, in_a, in_b, int_a, int_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire [1:0] pr = ser_o.proto;
  // one pin-0 hit on the second port
  sequence s_hit; cfg_b.ien[0] && in_b[0] == cfg_b.ipol[0]; endsequence
  a_input_quiet: assert property ((pad_a.oe & cfg_a.dir) == 8'h00) else $error("input driven");
  a_drive_style: assert property (pad_a.oe == (~cfg_a.dir & ~(cfg_a.mode ^ cfg_a.data))) else $error("bad style");
  // both earlier edges must be out of reset, or a mid-run reset leaves the pipe cleared
  a_sync_delay: assert property ($past(rstn) && $past(rstn, 2) |-> in_a == $past(pad_a_i, 2))
    else $error("bad delay");
  a_flag_set: assert property (s_hit |=> int_b[0]) else $error("flag not set");
  a_flag_hold: assert property ($past(rstn) |-> ($past(int_a) & ~$past(int_clr_a) & ~int_a) == 8'h00)
    else $error("flag lost");
  a_irq_any: assert property (irq == |{int_a, int_b}) else $error("bad irq");
  a_spi_dirs: assert property (pr == 2'h0 && fsel_b[2:0] == 3'h7 |-> pad_b.oe[2:0] ==
    {{2{ser_o.spi_master}}, !ser_o.spi_master}) else $error("bad spi dirs");
  a_uart_pins: assert property (pr == 2'h3 && fsel_b[2:0] == 3'h7 |-> pad_b.oe[2:0] == 3'h5 &&
    pad_b.o[2] == ser_o.rts_n) else $error("bad uart pins");
  a_twi_data: assert property (pr == 2'h1 && fsel_b[1] |-> pad_b.oe[1] == ser_o.twi_sda_low && !pad_b.o[1])
    else $error("bad twi data");
endmodule
bind gpx_port gpx_port_props props_inst (.*);

// File: test/gpx_port_tb.sv
// self-checking bench for the two-port gpio block
`timescale 1ns/1ns
module gpx_port_tb;
  logic clk, rstn, irq;
  gpx_pkg::gpx_cfg_t cfg_a, cfg_b;
  gpx_pkg::gpx_ser_out_t ser_o;
  gpx_pkg::gpx_ser_in_t ser_i;
  gpx_pkg::gpx_pad_t pad_a, pad_b;
  logic [7:0] fsel_b, int_clr_a, int_clr_b, pad_a_i, pad_b_i, in_a, in_b, int_a, int_b, ext_a, ext_b, e;
  int num_errors = 0, comparisons = 0, cycles = 0;
  // dir, mode, data, outside level, expected enables
  logic [39:0] rows [4] = '{40'hFF_00_00_A5_00, 40'h00_00_0F_3C_F0, 40'h00_FF_0F_3C_0F, 40'hF0_33_55_A5_09};
  // proto, master, expected enables, expected driven highs
  logic [8:0] modes [5] = '{9'h076, 9'h009, 9'h088, 9'h100, 9'h1A9};
  gpx_port gpx_port_inst (.*);
  gpx_ext ext_a_inst (.pad(pad_a), .ext(ext_a), .level(pad_a_i));
  gpx_ext ext_b_inst (.pad(pad_b), .ext(ext_b), .level(pad_b_i));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, tests need well under 200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    rstn = 1'b0;
    cfg_a = '0;
    cfg_b = '0;
    cfg_b.dir = 8'hF8;
    cfg_b.mode = 8'hFF;
    cfg_b.data = 8'h07;
    fsel_b = 8'hFF;
    int_clr_a = 8'h00;
    int_clr_b = 8'h00;
    ext_a = 8'h00;
    ext_b = 8'hF6;
    ser_o = '{gpx_pkg::GPX_PROTO_SPI, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    // drive styles and input path, whole port per row
    for (int r = 0; r < 4; r++) begin
      {cfg_a.dir, cfg_a.mode, cfg_a.data, ext_a, e} = rows[r];
      repeat (3) @(negedge clk);
      check(pad_a.oe, e);
      check(in_a, (cfg_a.data & e) | (ext_a & ~e));
      $display("row %0d done", r);
    end
    // high-level interrupt on pin 0, clear refused while level stays
    // all inputs, so only the outside level reaches the pin
    cfg_a.dir = 8'hFF;
    cfg_a.ien = 8'h01;
    cfg_a.ipol = 8'h01;
    ext_a = 8'h01;
    repeat (4) @(negedge clk);
    check(int_a, 8'h01);
    check({7'h00, irq}, 8'h01);
    int_clr_a = 8'h01;
    repeat (2) @(negedge clk);
    check(int_a, 8'h01);
    ext_a = 8'h00;
    repeat (4) @(negedge clk);
    check(int_a, 8'h00);
    int_clr_a = 8'h00;
    ext_a = 8'h01;
    repeat (4) @(negedge clk);
    rstn = 1'b0;
    #1 check(int_a, 8'h00);
    @(negedge clk);
    rstn = 1'b1;
    $display("interrupt test done");
    // serial protocols on the shared pins, low-level flags on port b
    cfg_b.ien = 8'h09;
    for (int r = 0; r < 5; r++) begin
      ser_o.proto = gpx_pkg::gpx_proto_t'(modes[r][8:7]);
      ser_o.spi_master = modes[r][6];
      @(negedge clk);
      check(pad_b.oe, {5'h00, modes[r][5:3]});
      check(pad_b.o & pad_b.oe, {5'h00, modes[r][2:0]});
    end
    check(int_b, 8'h09);
    // uart levels seen by the serial side after the synchroniser
    repeat (2) @(negedge clk);
    check({2'h0, ser_i}, 8'h37);
    fsel_b = 8'h00;
    @(negedge clk);
    check(pad_b.oe, 8'h07);
    check({2'h0, ser_i}, 8'h3F);
    $display("serial test done");
    finish_test();
  end
endmodule
